// ===== pwmo_pkg.sv
// Constants, field layout and action codes for the PWM output-action logic
// Behaviour
// - Bits 5:4 hold compare A up action
// - Compare-up events only in up/down mode
// - Action codes: keep, toggle, low, high
// - Bits 3:2 hold counter equals load action
// - Bits 1:0 hold counter equals zero action
// - Down mode four events, up/down six
// - Zero or load beats any compare
// - Output B: compare B beats compare A
// - Per-generator B control at 0x064/0x0A4/0x0E4
// - B output driven only by its events
// - Output A: compare A beats compare B
// - Bits 11:10 B down, 9:8 B up, 7:6 A down
package pwmo_pkg;

  localparam int GEN_COUNT = 3;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int CTL_W     = 12;
  localparam int ACT_W     = 2;

  // Byte addresses of the per-generator action registers
  localparam logic [GEN_COUNT-1:0][ADDR_W-1:0] OUT_A_OFS = {12'h0E0, 12'h0A0, 12'h060};
  localparam logic [GEN_COUNT-1:0][ADDR_W-1:0] OUT_B_OFS = {12'h0E4, 12'h0A4, 12'h064};
  localparam logic [ADDR_W-1:0] GEN_CTL_OFS = 12'h100;
  localparam logic [ADDR_W-1:0] OUT_STS_OFS = 12'h104;

  // Action field positions inside an output control register
  localparam int FLD_ZERO_LSB  = 0;
  localparam int FLD_LOAD_LSB  = 2;
  localparam int FLD_CAUP_LSB  = 4;
  localparam int FLD_CADN_LSB  = 6;
  localparam int FLD_CBUP_LSB  = 8;
  localparam int FLD_CBDN_LSB  = 10;

  localparam logic [CTL_W-1:0]     CTL_RESET  = 12'h000;
  localparam logic [GEN_COUNT-1:0] MODE_RESET = 3'h0;
  localparam logic                 OUT_RESET  = 1'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_LOW    = 2'h2,
    ACT_HIGH   = 2'h3
  } pwmo_act_e;

endpackage

// ===== pwmo_evt_if.sv
// Event and control bundle between the top and one output-action unit
`timescale 1ns/10ps
interface pwmo_evt_if;
  import pwmo_pkg::*;
  logic             cnt_zero;
  logic             cnt_load;
  logic             cmp_a;
  logic             cmp_b;
  logic             count_up;
  logic             mode_updown;
  logic [CTL_W-1:0] ctl;
  logic             out;

  modport src (output cnt_zero, cnt_load, cmp_a, cmp_b, count_up, mode_updown, ctl,
                input out);
  modport unit (input cnt_zero, cnt_load, cmp_a, cmp_b, count_up, mode_updown, ctl,
                output out);
endinterface

// ===== pwmo_action_unit.sv
// One PWM output: event priority and two-bit action applied to a registered level
`timescale 1ns/10ps
module pwmo_action_unit
  import pwmo_pkg::*;
#(
  parameter bit CMP_B_FIRST = 1'b0
) (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  clk_en,
  pwmo_evt_if.unit   ev
);

  wire       cmp_is_up   = ev.mode_updown & ev.count_up;
  wire [1:0] act_zero    = ev.ctl[FLD_ZERO_LSB +: ACT_W];
  wire [1:0] act_load    = ev.ctl[FLD_LOAD_LSB +: ACT_W];
  wire [1:0] act_a_up    = ev.ctl[FLD_CAUP_LSB +: ACT_W];
  wire [1:0] act_a_down  = ev.ctl[FLD_CADN_LSB +: ACT_W];
  wire [1:0] act_b_up    = ev.ctl[FLD_CBUP_LSB +: ACT_W];
  wire [1:0] act_b_down  = ev.ctl[FLD_CBDN_LSB +: ACT_W];
  // Down-only mode folds every compare match onto the down fields
  wire [1:0] act_cmp_a   = cmp_is_up ? act_a_up : act_a_down;
  wire [1:0] act_cmp_b   = cmp_is_up ? act_b_up : act_b_down;
  // Zero ranks above load; both happen together only with a zero load value
  wire       win_a       = ev.cmp_a & ~(CMP_B_FIRST & ev.cmp_b);
  wire [1:0] act_cmp     = win_a ? act_cmp_a : act_cmp_b;
  wire       any_cmp     = ev.cmp_a | ev.cmp_b;
  wire [1:0] act_sel     = ev.cnt_zero ? act_zero :
                           ev.cnt_load ? act_load :
                           any_cmp     ? act_cmp  : ACT_NONE;
  logic      out_next;

  always_comb begin
    unique case (pwmo_act_e'(act_sel))
      ACT_NONE:   out_next = ev.out;
      ACT_TOGGLE: out_next = ~ev.out;
      ACT_LOW:    out_next = 1'b0;
      ACT_HIGH:   out_next = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev.out <= OUT_RESET;
    end else if (clk_en) begin
      ev.out <= out_next;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire no_zl = ~ev.cnt_zero & ~ev.cnt_load;

  a_zero_drives_high: assert property (clk_en && ev.cnt_zero && act_zero == ACT_HIGH
    |=> ev.out) else $error("zero event did not set output");
  a_load_drives_low: assert property (clk_en && !ev.cnt_zero && ev.cnt_load
    && act_load == ACT_LOW |=> !ev.out) else $error("load event did not clear output");
  a_toggle_inverts: assert property (clk_en && ev.cnt_zero && act_zero == ACT_TOGGLE
    |=> ev.out != $past(ev.out)) else $error("toggle action did not invert");
  a_zl_beats_cmp: assert property (clk_en && ev.cnt_load && !ev.cnt_zero && any_cmp
    && act_load == ACT_NONE |=> $stable(ev.out)) else $error("compare overrode load");
  a_quiet_holds: assert property ((!clk_en || (no_zl && !any_cmp))
    |=> $stable(ev.out)) else $error("output moved without event");
  a_cmp_a_up: assert property (clk_en && no_zl && ev.cmp_a && !ev.cmp_b
    && ev.mode_updown && ev.count_up && act_a_up == ACT_HIGH |=> ev.out)
    else $error("compare A up action missed");
  a_down_only_map: assert property (clk_en && no_zl && ev.cmp_a && !ev.cmp_b
    && !ev.mode_updown && act_a_down == ACT_LOW |=> !ev.out)
    else $error("down-only mode used wrong field");
  a_cmp_order: assert property (clk_en && no_zl && ev.cmp_a && ev.cmp_b
    && act_cmp_a == ACT_HIGH && act_cmp_b == ACT_LOW
    |=> ev.out == !CMP_B_FIRST) else $error("compare priority wrong");

endmodule

// ===== pwmo_action_logic.sv
// Top of the PWM output-action logic: AXI4-Lite registers and six action units
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
module pwmo_action_logic
  import pwmo_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  // Counter and comparator pulses and count direction, one bit per generator
  input  wire logic [GEN_COUNT-1:0]  cnt_zero,
  input  wire logic [GEN_COUNT-1:0]  cnt_load,
  input  wire logic [GEN_COUNT-1:0]  cmp_a_match,
  input  wire logic [GEN_COUNT-1:0]  cmp_b_match,
  input  wire logic [GEN_COUNT-1:0]  cnt_dir_up,
  output logic      [GEN_COUNT-1:0]  gen_out_a,
  output logic      [GEN_COUNT-1:0]  gen_out_b,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [DATA_W/8-1:0]   s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  // Register storage
  logic [CTL_W-1:0]     out_a_ctl_reg [GEN_COUNT];
  logic [CTL_W-1:0]     out_b_ctl_reg [GEN_COUNT];
  logic [GEN_COUNT-1:0] gen_mode_reg;

  // Write channel state
  logic                 aw_held_reg;
  logic                 aw_held_next;
  logic                 w_held_reg;
  logic                 w_held_next;
  logic [ADDR_W-1:0]    waddr_reg;
  logic [DATA_W-1:0]    wdata_reg;
  logic [DATA_W/8-1:0]  wstrb_reg;
  logic                 awready_reg;
  logic                 wready_reg;
  logic                 bvalid_reg;
  logic                 bvalid_next;
  logic [1:0]           bresp_reg;

  // Read channel state
  logic                 arready_reg;
  logic                 rvalid_reg;
  logic                 rvalid_next;
  logic [DATA_W-1:0]    rdata_reg;
  logic [1:0]           rresp_reg;

  // Handshakes
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take  = s_axi_wvalid & wready_reg;
  wire ar_take = s_axi_arvalid & arready_reg;
  // A write commits only once both halves are held and the last response is gone
  wire wr_commit = aw_held_reg & w_held_reg & ~bvalid_reg;

  assign aw_held_next = wr_commit ? 1'b0 : (aw_take | aw_held_reg);
  assign w_held_next  = wr_commit ? 1'b0 : (w_take | w_held_reg);
  assign bvalid_next  = wr_commit | (bvalid_reg & ~s_axi_bready);
  assign rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready);

  // Write and read address decode
  logic [GEN_COUNT-1:0] wr_hit_a;
  logic [GEN_COUNT-1:0] wr_hit_b;
  logic [GEN_COUNT-1:0] rd_hit_a;
  logic [GEN_COUNT-1:0] rd_hit_b;

  wire wr_hit_mode = (waddr_reg == GEN_CTL_OFS);
  wire wr_hit_sts  = (waddr_reg == OUT_STS_OFS);
  wire wr_mapped   = (|wr_hit_a) | (|wr_hit_b) | wr_hit_mode | wr_hit_sts;
  wire rd_hit_mode = (s_axi_araddr == GEN_CTL_OFS);
  wire rd_hit_sts  = (s_axi_araddr == OUT_STS_OFS);
  wire rd_mapped   = (|rd_hit_a) | (|rd_hit_b) | rd_hit_mode | rd_hit_sts;

  // Merge byte lanes; bits above the stored width are dropped
  function automatic logic [CTL_W-1:0] merge_ctl(input logic [CTL_W-1:0]    old_v,
                                                 input logic [DATA_W-1:0]   new_v,
                                                 input logic [DATA_W/8-1:0] strb);
    logic [CTL_W-1:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      res[CTL_W-1:8] = new_v[CTL_W-1:8];
    end
    return res;
  endfunction

  // Read data slots, one per register, OR-combined below
  logic [DATA_W-1:0] rd_slot_a [GEN_COUNT];
  logic [DATA_W-1:0] rd_slot_b [GEN_COUNT];
  logic [DATA_W-1:0] rd_word;

  wire [DATA_W-1:0] rd_mode_word = rd_hit_mode ?
                                   {{(DATA_W-GEN_COUNT){1'b0}}, gen_mode_reg} : '0;
  wire [DATA_W-1:0] rd_sts_word  = rd_hit_sts ?
                                   {{(DATA_W-2*GEN_COUNT){1'b0}}, gen_out_b, gen_out_a} : '0;

  always_comb begin
    rd_word = rd_mode_word | rd_sts_word;
    for (int g = 0; g < GEN_COUNT; g++) begin
      rd_word = rd_word | rd_slot_a[g] | rd_slot_b[g];
    end
  end

  // Per-generator decode, registers and the two output units
  for (genvar g = 0; g < GEN_COUNT; g++) begin : gen_blk
    pwmo_evt_if ev_a ();
    pwmo_evt_if ev_b ();

    assign wr_hit_a[g] = (waddr_reg == OUT_A_OFS[g]);
    assign wr_hit_b[g] = (waddr_reg == OUT_B_OFS[g]);
    assign rd_hit_a[g] = (s_axi_araddr == OUT_A_OFS[g]);
    assign rd_hit_b[g] = (s_axi_araddr == OUT_B_OFS[g]);
    assign rd_slot_a[g] = rd_hit_a[g] ? {{(DATA_W-CTL_W){1'b0}}, out_a_ctl_reg[g]} : '0;
    assign rd_slot_b[g] = rd_hit_b[g] ? {{(DATA_W-CTL_W){1'b0}}, out_b_ctl_reg[g]} : '0;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_a_ctl_reg[g] <= CTL_RESET;
        out_b_ctl_reg[g] <= CTL_RESET;
      end else if (clk_en && wr_commit) begin
        if (wr_hit_a[g]) begin
          out_a_ctl_reg[g] <= merge_ctl(out_a_ctl_reg[g], wdata_reg, wstrb_reg);
        end
        if (wr_hit_b[g]) begin
          out_b_ctl_reg[g] <= merge_ctl(out_b_ctl_reg[g], wdata_reg, wstrb_reg);
        end
      end
    end

    // Both outputs see the same events; only priority and field set differ
    assign ev_a.cnt_zero    = cnt_zero[g];
    assign ev_a.cnt_load    = cnt_load[g];
    assign ev_a.cmp_a       = cmp_a_match[g];
    assign ev_a.cmp_b       = cmp_b_match[g];
    assign ev_a.count_up    = cnt_dir_up[g];
    assign ev_a.mode_updown = gen_mode_reg[g];
    assign ev_a.ctl         = out_a_ctl_reg[g];

    assign ev_b.cnt_zero    = cnt_zero[g];
    assign ev_b.cnt_load    = cnt_load[g];
    assign ev_b.cmp_a       = cmp_a_match[g];
    assign ev_b.cmp_b       = cmp_b_match[g];
    assign ev_b.count_up    = cnt_dir_up[g];
    assign ev_b.mode_updown = gen_mode_reg[g];
    assign ev_b.ctl         = out_b_ctl_reg[g];

    pwmo_action_unit #(
      .CMP_B_FIRST (1'b0)
    ) u_out_a (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clk_en  (clk_en),
      .ev      (ev_a)
    );

    pwmo_action_unit #(
      .CMP_B_FIRST (1'b1)
    ) u_out_b (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clk_en  (clk_en),
      .ev      (ev_b)
    );

    // Unit flops drive the pins directly
    assign gen_out_a[g] = ev_a.out;
    assign gen_out_b[g] = ev_b.out;
  end

  // Counting-mode register, one bit per generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_mode_reg <= MODE_RESET;
    end else if (clk_en && wr_commit && wr_hit_mode && wstrb_reg[0]) begin
      gen_mode_reg <= wdata_reg[GEN_COUNT-1:0];
    end
  end

  // Write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else if (clk_en) begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awready_reg <= ~aw_held_next;
      wready_reg  <= ~w_held_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (clk_en) begin
      if (aw_take) begin
        waddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Write response; the status word is read-only, so writing it is an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (clk_en) begin
      bvalid_reg <= bvalid_next;
      if (wr_commit) begin
        bresp_reg <= (wr_mapped && !wr_hit_sts) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channel; the address is sampled at the handshake edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else if (clk_en) begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_both_held;
    clk_en && aw_held_reg && w_held_reg && !bvalid_reg;
  endsequence

  sequence s_read_taken;
    clk_en && s_axi_arvalid && s_axi_arready;
  endsequence

  a_bvalid_hold: assert property (clk_en && s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped early");
  a_write_answer: assert property (s_both_held |=> s_axi_bvalid ##0 !s_axi_awready == 1'b0)
    else $error("write commit gave no response");
  a_read_answer: assert property (s_read_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_gen0_b_read: assert property (s_read_taken ##0 (s_axi_araddr == OUT_B_OFS[0])
    |=> s_axi_rdata == {{(DATA_W-CTL_W){1'b0}}, $past(out_b_ctl_reg[0])})
    else $error("gen0 B control readback wrong");
  a_gen1_b_write: assert property (s_both_held ##0 (waddr_reg == OUT_B_OFS[1])
    && (wstrb_reg[1:0] == 2'h3)
    |=> out_b_ctl_reg[1] == $past(wdata_reg[CTL_W-1:0]) && $stable(out_b_ctl_reg[0]))
    else $error("gen1 B control write wrong");
  a_unmapped_err: assert property (s_read_taken ##0 !rd_mapped
    |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
  a_freeze_all: assert property (!clk_en |=> $stable(gen_out_a) && $stable(gen_out_b)
    && $stable(s_axi_bvalid) && $stable(s_axi_rvalid)) else $error("state moved while frozen");

  sequence s_write_taken;
    clk_en && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_addr_taken;
    clk_en && s_axi_awvalid && s_axi_awready;
  endsequence

  a_rvalid_hold: assert property (clk_en && s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp))
    else $error("read data changed before accept");
  a_bresp_hold: assert property (clk_en && s_axi_bvalid && !s_axi_bready
    |=> $stable(s_axi_bresp))
    else $error("write response changed early");
  a_w_take_stall: assert property (s_write_taken
    |=> !s_axi_wready)
    else $error("write data taken twice");
  a_aw_take_stall: assert property (s_addr_taken
    |=> !s_axi_awready)
    else $error("write address taken twice");
  a_sts_write_err: assert property (s_both_held ##0 wr_hit_sts
    |=> s_axi_bresp == RESP_SLVERR)
    else $error("status write not refused");
  a_unmapped_wr: assert property (s_both_held ##0 !wr_mapped
    |=> s_axi_bresp == RESP_SLVERR && $stable(gen_mode_reg))
    else $error("unmapped write not refused");
  a_mode_write: assert property (s_both_held ##0 (wr_hit_mode && wstrb_reg[0])
    |=> gen_mode_reg == $past(wdata_reg[GEN_COUNT-1:0]))
    else $error("mode bits not written");
  a_gen0_b_write: assert property (s_both_held ##0 (waddr_reg == OUT_B_OFS[0])
    && (wstrb_reg[1:0] == 2'h3)
    |=> out_b_ctl_reg[0] == $past(wdata_reg[CTL_W-1:0]) && $stable(out_a_ctl_reg[0])
    && $stable(out_b_ctl_reg[1]) && $stable(out_b_ctl_reg[2]))
    else $error("gen0 B control write wrong");
  a_gen2_b_read: assert property (s_read_taken ##0 (s_axi_araddr == OUT_B_OFS[2])
    |=> s_axi_rdata == {{(DATA_W-CTL_W){1'b0}}, $past(out_b_ctl_reg[2])})
    else $error("gen2 B control readback wrong");
  a_status_read: assert property (s_read_taken ##0 rd_hit_sts
    |=> s_axi_rdata == {{(DATA_W-2*GEN_COUNT){1'b0}}, $past(gen_out_b), $past(gen_out_a)})
    else $error("status readback wrong");
  a_read_mapped_ok: assert property (s_read_taken ##0 rd_mapped
    |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  a_write_mapped_ok: assert property (s_both_held ##0 (wr_mapped && !wr_hit_sts)
    |=> s_axi_bresp == RESP_OKAY)
    else $error("mapped write refused");

endmodule

// ===== pwmo_action_logic_tb.sv
// Self-checking testbench for the PWM output-action logic
`timescale 1ns/10ps
module pwmo_action_logic_tb;
  import pwmo_pkg::*;
  logic                 aclk;
  logic                 aresetn;
  logic                 clk_en;
  logic [GEN_COUNT-1:0] cnt_zero, cnt_load, cmp_a_match, cmp_b_match, cnt_dir_up;
  logic [GEN_COUNT-1:0] gen_out_a, gen_out_b;
  logic [ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]    s_axi_wdata, s_axi_rdata;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                 s_axi_rvalid, s_axi_rready;
  logic [CTL_W-1:0]     ctl_a [GEN_COUNT];
  logic [CTL_W-1:0]     ctl_b [GEN_COUNT];
  logic [GEN_COUNT-1:0] mode_bits, exp_a, exp_b;
  int                   fails, tests_run, lag;
  // Events as {zero, load, cmp_a, cmp_b}; coincidences exercise the priority chain
  logic [3:0]           evs [7] = '{4'h3, 4'h4, 4'h7, 4'hB, 4'hC, 4'h2, 4'h1};
  logic [1:0]           codes [6] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h2, 2'h3};

  pwmo_action_logic pwmo_action_logic_i (
    .aclk, .aresetn, .clk_en, .cnt_zero, .cnt_load, .cmp_a_match, .cmp_b_match,
    .cnt_dir_up, .gen_out_a, .gen_out_b,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  always #12.5 aclk = ~aclk;

  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    fails++;
    $display("BAD %s expected handshake seen none", what);
    stop_test();
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_out(input string name, input logic [GEN_COUNT-1:0] exp,
                         input logic [GEN_COUNT-1:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Handshakes are sampled at the falling edge, where the slave outputs are settled
  task automatic axi_write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
                           input logic [3:0] strb, input logic [1:0] exp_resp);
    logic       aw_tk, w_tk, b_tk, done;
    logic [1:0] r;
    int         n;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= data;
    s_axi_wstrb   <= strb;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= (lag == 0);
    for (n = 0; n < 100 && !done; n++) begin
      @(negedge aclk);
      aw_tk = s_axi_awvalid && s_axi_awready;
      w_tk  = s_axi_wvalid && s_axi_wready;
      b_tk  = s_axi_bvalid && s_axi_bready;
      r     = s_axi_bresp;
      @(posedge aclk);
      if (aw_tk) s_axi_awvalid <= 1'b0;
      if (w_tk) s_axi_wvalid <= 1'b0;
      if (b_tk) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end else if (n + 1 >= lag) begin
        s_axi_bready <= 1'b1;
      end
    end
    if (!done) timed_out("write");
    chk_word("bresp", {30'h0, exp_resp}, {30'h0, r});
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp_data,
                          input logic [1:0] exp_resp);
    logic              ar_tk, r_tk, done;
    logic [DATA_W-1:0] d;
    logic [1:0]        r;
    int                n;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= (lag == 0);
    for (n = 0; n < 100 && !done; n++) begin
      @(negedge aclk);
      ar_tk = s_axi_arvalid && s_axi_arready;
      r_tk  = s_axi_rvalid && s_axi_rready;
      d     = s_axi_rdata;
      r     = s_axi_rresp;
      @(posedge aclk);
      if (ar_tk) s_axi_arvalid <= 1'b0;
      if (r_tk) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end else if (n + 1 >= lag) begin
        s_axi_rready <= 1'b1;
      end
    end
    if (!done) timed_out("read");
    chk_word("rdata", exp_data, d);
    chk_word("rresp", {30'h0, exp_resp}, {30'h0, r});
  endtask

  task automatic set_ctl(input int g, input logic isb, input logic [CTL_W-1:0] v);
    axi_write(isb ? OUT_B_OFS[g] : OUT_A_OFS[g], {20'h0, v}, 4'hF, RESP_OKAY);
    if (isb) ctl_b[g] = v;
    else ctl_a[g] = v;
  endtask

  function automatic logic apply_act(input logic cur, input logic [1:0] code);
    case (code)
      2'h1:    apply_act = ~cur;
      2'h2:    apply_act = 1'b0;
      2'h3:    apply_act = 1'b1;
      default: apply_act = cur;
    endcase
  endfunction

  // Reference for one output: zero, then load, then the compare that this output prefers
  function automatic logic next_lvl(input logic cur, input logic [CTL_W-1:0] c,
                                    input logic [3:0] ev, input logic up, input logic isb);
    logic use_b;
    int   lsb;
    use_b = isb ? ev[0] : (ev[0] && !ev[1]);
    lsb   = (use_b ? 8 : 4) + (up ? 0 : 2);
    if (ev[3]) return apply_act(cur, c[1:0]);
    if (ev[2]) return apply_act(cur, c[3:2]);
    if (ev[1] || ev[0]) return apply_act(cur, c[lsb+:2]);
    return cur;
  endfunction

  task automatic fire(input int g, input logic [3:0] ev, input logic dir, input logic en);
    logic up;
    up = mode_bits[g] && dir;
    @(posedge aclk);
    clk_en         <= en;
    cnt_zero[g]    <= ev[3];
    cnt_load[g]    <= ev[2];
    cmp_a_match[g] <= ev[1];
    cmp_b_match[g] <= ev[0];
    cnt_dir_up[g]  <= dir;
    @(posedge aclk);
    clk_en      <= 1'b1;
    cnt_zero    <= '0;
    cnt_load    <= '0;
    cmp_a_match <= '0;
    cmp_b_match <= '0;
    if (en) begin
      exp_a[g] = next_lvl(exp_a[g], ctl_a[g], ev, up, 1'b0);
      exp_b[g] = next_lvl(exp_b[g], ctl_b[g], ev, up, 1'b1);
    end
    #1;
    chk_out("gen_out_a", exp_a, gen_out_a);
    chk_out("gen_out_b", exp_b, gen_out_b);
  endtask

  initial begin
    int g, c, k;
    aclk = 1'b0;
    aresetn = 1'b0;
    clk_en = 1'b1;
    {cnt_zero, cnt_load, cmp_a_match, cmp_b_match, cnt_dir_up} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {mode_bits, exp_a, exp_b} = '0;
    fails = 0;
    tests_run = 0;
    lag = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk_out("gen_out_a", 3'h0, gen_out_a);
    chk_out("gen_out_b", 3'h0, gen_out_b);
    for (g = 0; g < GEN_COUNT; g++) begin
      axi_read(OUT_A_OFS[g], 32'h0, RESP_OKAY);
      axi_read(OUT_B_OFS[g], 32'h0, RESP_OKAY);
      ctl_a[g] = '0;
      ctl_b[g] = '0;
    end
    axi_read(GEN_CTL_OFS, 32'h0, RESP_OKAY);
    $display("test reset done");
    // Field widths, byte strobes, per-generator separation and refused accesses
    axi_write(OUT_B_OFS[0], 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    axi_read(OUT_B_OFS[0], 32'h00000FFF, RESP_OKAY);
    axi_write(OUT_B_OFS[1], 32'h00000ABC, 4'h1, RESP_OKAY);
    axi_read(OUT_B_OFS[1], 32'h000000BC, RESP_OKAY);
    axi_read(OUT_B_OFS[2], 32'h0, RESP_OKAY);
    axi_read(OUT_A_OFS[0], 32'h0, RESP_OKAY);
    // Late bready and rready: responses must stand until taken
    lag = 3;
    axi_write(OUT_B_OFS[2], 32'h00000123, 4'h3, RESP_OKAY);
    axi_read(OUT_B_OFS[2], 32'h00000123, RESP_OKAY);
    lag = 0;
    axi_read(12'h010, 32'h0, RESP_SLVERR);
    axi_write(12'h200, 32'h0000000F, 4'hF, RESP_SLVERR);
    axi_write(OUT_STS_OFS, 32'h0000003F, 4'hF, RESP_SLVERR);
    $display("test registers done");
    // Every action code on the zero event; A and B get different codes
    for (g = 0; g < GEN_COUNT; g++) begin
      for (k = 0; k < 6; k++) begin
        set_ctl(g, 1'b1, {10'h0, codes[k]});
        set_ctl(g, 1'b0, {10'h0, ~codes[k]});
        fire(g, 4'h8, 1'b0, 1'b0);
        fire(g, 4'h8, 1'b0, 1'b1);
      end
    end
    $display("test action codes done");
    // Compare A down high, B down low, A up low, B up high; load toggles, zero drives low
    for (c = 0; c < 3; c++) begin
      axi_write(GEN_CTL_OFS, (c == 0) ? 32'h0 : 32'h7, 4'hF, RESP_OKAY);
      mode_bits = (c == 0) ? 3'h0 : 3'h7;
      axi_read(GEN_CTL_OFS, {29'h0, mode_bits}, RESP_OKAY);
      for (g = 0; g < GEN_COUNT; g++) begin
        set_ctl(g, 1'b0, 12'hBE6);
        set_ctl(g, 1'b1, 12'hBE6);
        for (k = 0; k < 7; k++) begin
          fire(g, evs[k], c != 2, 1'b1);
        end
      end
    end
    axi_read(OUT_STS_OFS, {26'h0, exp_b, exp_a}, RESP_OKAY);
    $display("test priority and modes done");
    stop_test();
  end
endmodule
